/* File: planar_write_read_pkg.sv */
// Constants for the planar write/read data path of the graphics controller.
// Assumes an 8-bit host I/O port interface and four byte-wide display maps.
package planar_write_read_pkg;

    // ------------------------------------------------------------------
    // Host I/O ports
    // ------------------------------------------------------------------
    localparam logic [15:0] INDEX_PORT = 16'h03ce;
    localparam logic [15:0] DATA_PORT  = 16'h03cf;

    // ------------------------------------------------------------------
    // Register indices behind the data port
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_FILL_VALUE    = 4'h0;
    localparam logic [3:0] IDX_FILL_SOURCE   = 4'h1;
    localparam logic [3:0] IDX_COMPARE_REF   = 4'h2;
    localparam logic [3:0] IDX_ROTATE_LOGIC  = 4'h3;
    localparam logic [3:0] IDX_READ_PLANE    = 4'h4;
    localparam logic [3:0] IDX_WRITE_READ    = 4'h5;
    localparam logic [3:0] IDX_MEM_WINDOW    = 4'h6;
    localparam logic [3:0] IDX_COMPARE_EN    = 4'h7;
    localparam logic [3:0] IDX_WRITE_PROTECT = 4'h8;

    // ------------------------------------------------------------------
    // Implemented bits of each register, reset value
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_INDEX   = 8'h0f;
    localparam logic [7:0] MASK_NIBBLE  = 8'h0f;
    localparam logic [7:0] MASK_ROTATE  = 8'h1f;
    localparam logic [7:0] MASK_PLANE   = 8'h03;
    localparam logic [7:0] MASK_METHOD  = 8'h7b;
    localparam logic [7:0] MASK_FULL    = 8'hff;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ROT_COUNT_LSB  = 0;
    localparam int FUNC_LSB       = 3;
    localparam int WMODE_LSB      = 0;
    localparam int READ_TYPE_BIT  = 3;
    localparam int PLANE_SEL_LSB  = 0;

    // Write modes and logical functions
    typedef enum logic [1:0] {
        WMODE_FILL   = 2'h0,
        WMODE_LATCH  = 2'h1,
        WMODE_SPREAD = 2'h2,
        WMODE_MASKED = 2'h3
    } wmode_type;

    typedef enum logic [1:0] {
        FN_PASS = 2'h0,
        FN_AND  = 2'h1,
        FN_OR   = 2'h2,
        FN_XOR  = 2'h3
    } func_type;

endpackage

/* File: planar_write_read_datapath.sv */
// Graphics controller data path: index/data register file, write modes,
// logical function, bit masking, read latches and colour compare.
// Assumes host strobes and map data come from logic on core_clk.
//
// How it works
// RQ1 - Index port low nibble selects data register
// RQ2 - Indices above eight reach vendor extension registers
// RQ3 - Software writes zero to reserved bits
// RQ4 - Mode 0 enabled maps take fill bit
// RQ5 - Mode 0 disabled maps take rotated byte
// RQ6 - Mode 0 means mode bits both zero
// RQ7 - Compare read returns ones where maps match
// RQ8 - Read type zero returns plain map data
// RQ9 - Function field: pass, AND, OR, XOR
// RQ10 - Three-bit rotate count held in register
// RQ11 - Rotate right, old LSB becomes MSB
// RQ12 - Read type picks compare or selected map
// RQ13 - Mask zero bits keep latched value
// RQ14 - Every map read loads 32-bit latches
// RQ15 - Reserved bits read zero, no effect
`timescale 1ns/1ps

module planar_write_read_datapath (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Host I/O port access
    input  wire logic [15:0] ioAddr,
    input  wire logic        ioWr,
    input  wire logic        ioRd,
    input  wire logic [7:0]  ioWrData,
    output logic      [7:0]  ioRdData,
    // Host display memory access
    input  wire logic        memWr,
    input  wire logic        memRd,
    input  wire logic [7:0]  cpuWrData,
    output logic      [7:0]  memRdData,
    output logic             memRdValid,
    // Display maps, map n in bits 8n+7..8n
    input  wire logic [31:0] mapRdData,
    output logic      [31:0] mapWrData,
    output logic             mapWrEn,
    // Memory window setup for address logic
    output logic      [3:0]  windowSetup,
    output logic      [1:0]  oddEvenMode
);

    // ------------------------------------------------------------------
    // Decoding functions
    // ------------------------------------------------------------------

    // Implemented bits of each indexed register
    function automatic logic [7:0] regMask(input logic [3:0] idx);
        if (idx == planar_write_read_pkg::IDX_ROTATE_LOGIC) begin
            return planar_write_read_pkg::MASK_ROTATE;
        end else if (idx == planar_write_read_pkg::IDX_READ_PLANE) begin
            return planar_write_read_pkg::MASK_PLANE;
        end else if (idx == planar_write_read_pkg::IDX_WRITE_READ) begin
            return planar_write_read_pkg::MASK_METHOD;
        end else if (idx == planar_write_read_pkg::IDX_WRITE_PROTECT) begin
            return planar_write_read_pkg::MASK_FULL;
        end else if (idx > planar_write_read_pkg::IDX_WRITE_PROTECT) begin
            return planar_write_read_pkg::MASK_FULL;
        end else begin
            return planar_write_read_pkg::MASK_NIBBLE;
        end
    endfunction

    // Logical function of source byte against latch byte
    function automatic logic [7:0] logicOp(input logic [1:0] fn,
                                           input logic [7:0] src,
                                           input logic [7:0] lat);
        case (fn)
            planar_write_read_pkg::FN_AND: return src & lat;
            planar_write_read_pkg::FN_OR:  return src | lat;
            planar_write_read_pkg::FN_XOR: return src ^ lat;
            default:                       return src;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [3:0]  idx_ff;
    logic [7:0]  gcReg_ff [16];
    logic        idxSel;
    logic        dataSel;

    assign idxSel  = (ioAddr == planar_write_read_pkg::INDEX_PORT);
    assign dataSel = (ioAddr == planar_write_read_pkg::DATA_PORT);

    // Index pointer, upper bits dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_ff <= 4'h0;
        end else if (ioWr && idxSel) begin
            idx_ff <= ioWrData[3:0]; // RQ1
        end
    end

    // Indexed registers, standard and extension alike
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                gcReg_ff[i] <= planar_write_read_pkg::REG_RESET;
            end
        end else if (ioWr && dataSel) begin
            gcReg_ff[idx_ff] <= ioWrData & regMask(idx_ff); // RQ2 RQ15
        end
    end

    // Port readback, registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ioRdData <= 8'h00;
        end else if (ioRd && idxSel) begin
            ioRdData <= {4'h0, idx_ff};
        end else if (ioRd && dataSel) begin
            ioRdData <= gcReg_ff[idx_ff]; // RQ1 RQ2
        end else if (ioRd) begin
            ioRdData <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    logic [3:0] fillVal;
    logic [3:0] fillEn;
    logic [3:0] cmpRef;
    logic [3:0] cmpEn;
    logic [2:0] rotCount;
    logic [1:0] func;
    logic [1:0] planeSel;
    logic [1:0] wmode;
    logic       readType;
    logic       modeZero;
    logic [7:0] protect;

    assign fillVal  = gcReg_ff[planar_write_read_pkg::IDX_FILL_VALUE][3:0];
    assign fillEn   = gcReg_ff[planar_write_read_pkg::IDX_FILL_SOURCE][3:0];
    assign cmpRef   = gcReg_ff[planar_write_read_pkg::IDX_COMPARE_REF][3:0];
    assign cmpEn    = gcReg_ff[planar_write_read_pkg::IDX_COMPARE_EN][3:0];
    assign rotCount = gcReg_ff[planar_write_read_pkg::IDX_ROTATE_LOGIC]
                      [planar_write_read_pkg::ROT_COUNT_LSB +: 3]; // RQ10
    assign func     = gcReg_ff[planar_write_read_pkg::IDX_ROTATE_LOGIC]
                      [planar_write_read_pkg::FUNC_LSB +: 2];
    assign planeSel = gcReg_ff[planar_write_read_pkg::IDX_READ_PLANE]
                      [planar_write_read_pkg::PLANE_SEL_LSB +: 2];
    assign wmode    = gcReg_ff[planar_write_read_pkg::IDX_WRITE_READ]
                      [planar_write_read_pkg::WMODE_LSB +: 2];
    assign readType = gcReg_ff[planar_write_read_pkg::IDX_WRITE_READ]
                      [planar_write_read_pkg::READ_TYPE_BIT];
    assign protect  = gcReg_ff[planar_write_read_pkg::IDX_WRITE_PROTECT];
    assign modeZero = (wmode == planar_write_read_pkg::WMODE_FILL); // RQ6

    // Memory window and odd/even bits for the address logic
    assign windowSetup = gcReg_ff[planar_write_read_pkg::IDX_MEM_WINDOW][3:0];
    assign oddEvenMode = {gcReg_ff[planar_write_read_pkg::IDX_WRITE_READ][4],
                          windowSetup[1]};

    // ------------------------------------------------------------------
    // Read latches and read data
    // ------------------------------------------------------------------
    logic [31:0] latch_ff;
    logic [7:0]  cmpByte;
    logic [7:0]  plainByte;

    // Every map read refreshes all four latches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_ff <= 32'h0000_0000;
        end else if (memRd) begin
            latch_ff <= mapRdData; // RQ14
        end
    end

    // Per-bit colour compare across enabled maps
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_cmp
            assign cmpByte[b] = &(~cmpEn | ~(cmpRef ^ {mapRdData[24 + b],
                                mapRdData[16 + b], mapRdData[8 + b],
                                mapRdData[b]})); // RQ7
        end
    endgenerate

    assign plainByte = mapRdData[{planeSel, 3'h0} +: 8];

    // Read result: compare byte or selected map
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            memRdData  <= 8'h00;
            memRdValid <= 1'b0;
        end else begin
            memRdValid <= memRd;
            if (memRd) begin
                memRdData <= readType ? cmpByte : plainByte; // RQ8 RQ12
            end
        end
    end

    // ------------------------------------------------------------------
    // Write data path
    // ------------------------------------------------------------------
    logic [7:0]  rotData;
    logic [7:0]  wrMask;
    logic [15:0] rotPair;
    logic [31:0] nxt_mapWrData;

    // Rotate right, low bits wrap into the top
    assign rotPair = {cpuWrData, cpuWrData} >> rotCount; // RQ11
    assign rotData = rotPair[7:0];

    // Mode 3 narrows the protect pattern by the rotated byte
    assign wrMask = (wmode == planar_write_read_pkg::WMODE_MASKED) ?
                    (rotData & protect) : protect;

    genvar m;
    generate
        for (m = 0; m < 4; m++) begin : g_map
            logic [7:0] src;
            logic [7:0] alu;
            logic [7:0] lat;
            assign lat = latch_ff[8 * m +: 8];
            // Source byte per write mode
            always_comb begin
                case (wmode)
                    planar_write_read_pkg::WMODE_FILL:
                        src = fillEn[m] ? {8{fillVal[m]}} : rotData; // RQ4 RQ5
                    planar_write_read_pkg::WMODE_SPREAD:
                        src = {8{cpuWrData[m]}};
                    planar_write_read_pkg::WMODE_MASKED:
                        src = {8{fillVal[m]}};
                    default:
                        src = lat;
                endcase
            end
            assign alu = logicOp(func, src, lat); // RQ9
            // Masked bits keep the latch; mode 1 copies latches
            assign nxt_mapWrData[8 * m +: 8] =
                (wmode == planar_write_read_pkg::WMODE_LATCH) ? lat :
                ((alu & wrMask) | (lat & ~wrMask)); // RQ13
        end
    endgenerate

    // Map write data and strobe, registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mapWrData <= 32'h0000_0000;
            mapWrEn   <= 1'b0;
        end else begin
            mapWrEn <= memWr;
            if (memWr) begin
                mapWrData <= nxt_mapWrData;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_plainWr;
        memWr && modeZero && func == 2'h0 && protect == 8'hff;
    endsequence

    a_index_pointer: assert property ( // RQ1
        ioWr && idxSel |=> idx_ff == $past(ioWrData[3:0]))
        else $error("index pointer not loaded");

    a_ext_register: assert property ( // RQ2
        ioWr && dataSel && idx_ff > 4'h8 ##2 ioRd && dataSel && !ioWr
        && idx_ff == $past(idx_ff) |=> ioRdData == $past(ioWrData, 3))
        else $error("extension register readback wrong");

    a_fill_plane: assert property ( // RQ4
        s_plainWr ##0 fillEn[0] |=> mapWrEn && mapWrData[7:0] == {8{$past(fillVal[0])}})
        else $error("fill byte wrong");

    a_rotate_plane: assert property ( // RQ5
        s_plainWr ##0 !fillEn[1] && rotCount == 3'h1 |=>
        mapWrData[15:8] == {$past(cpuWrData[0]), $past(cpuWrData[7:1])})
        else $error("rotated byte wrong");

    a_compare_all: assert property ( // RQ7
        memRd && readType && cmpEn == 4'hf && cmpRef == 4'h0
        && mapRdData == 32'h0000_0000 |=> memRdData == 8'hff && memRdValid)
        else $error("compare read wrong");

    a_direct_read: assert property ( // RQ8
        memRd && !readType && planeSel == 2'h2 |=>
        memRdData == $past(mapRdData[23:16]))
        else $error("direct read wrong");

    a_xor_function: assert property ( // RQ9
        memWr && modeZero && fillEn[2] == 1'b0 && rotCount == 3'h0
        && func == 2'h3 && protect == 8'hff |=>
        mapWrData[23:16] == ($past(cpuWrData) ^ $past(latch_ff[23:16])))
        else $error("xor function wrong");

    a_mask_keeps: assert property ( // RQ13
        memWr && protect == 8'h00 && wmode != 2'h1 |=> mapWrData == $past(latch_ff))
        else $error("protected bits changed");

    a_latch_load: assert property ( // RQ14
        memRd |=> latch_ff == $past(mapRdData))
        else $error("latches not loaded");

    a_reserved_zero: assert property ( // RQ15
        ioRd && dataSel && idx_ff == 4'h4 |=> ioRdData[7:2] == 6'h00)
        else $error("reserved bits not zero");

endmodule

/* File: display_map_model.sv */
// Behavioural model of the four display maps at one byte address.
// Assumes the data path drives mapWrEn for one cycle per write.
`timescale 1ns/1ps

module display_map_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Bench preload
    input  wire logic        presetEn,
    input  wire logic [31:0] presetData,
    // Map side of the data path
    input  wire logic        memRd,
    input  wire logic        mapWrEn,
    input  wire logic [31:0] mapWrData,
    output logic      [31:0] mapRdData
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [31:0] mapStore_ff;

    // Store preload or written map bytes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mapStore_ff <= 32'h00000000;
        end else if (presetEn) begin
            mapStore_ff <= presetData;
        end else if (mapWrEn) begin
            mapStore_ff <= mapWrData;
        end
    end

    // Lines show stored data only during a read
    assign mapRdData = memRd ? mapStore_ff : ~mapStore_ff;
endmodule

/* File: test_planar_write_read_datapath.sv */
// Self-checking bench for the planar write/read data path.
// Assumes the display map model above stands on the map side.
`timescale 1ns/1ps

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_planar_write_read_datapath;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        core_clk, rst_n, ioWr, ioRd, memWr, memRd, presetEn, memRdValid, mapWrEn;
    logic [15:0] ioAddr;
    logic [7:0]  ioWrData, ioRdData, cpuWrData, memRdData, mask, cpu, cen;
    logic [31:0] mapRdData, mapWrData, presetData, maps;
    logic [3:0]  windowSetup;
    logic [1:0]  oddEvenMode, mode, fn;
    logic [2:0]  rot;
    logic [7:0]  regMask [9];
    int          n_mismatch, total_checks, cycles;

    planar_write_read_datapath DUT (.core_clk(core_clk), .rst_n(rst_n), .ioAddr(ioAddr),
        .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData), .memWr(memWr),
        .memRd(memRd), .cpuWrData(cpuWrData), .memRdData(memRdData), .memRdValid(memRdValid),
        .mapRdData(mapRdData), .mapWrData(mapWrData), .mapWrEn(mapWrEn),
        .windowSetup(windowSetup), .oddEvenMode(oddEvenMode));
    display_map_model mapModel (.core_clk(core_clk), .rst_n(rst_n), .presetEn(presetEn),
        .presetData(presetData), .memRd(memRd), .mapWrEn(mapWrEn), .mapWrData(mapWrData),
        .mapRdData(mapRdData));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Access tasks and expected values
    // ------------------------------------------------------------------
    task automatic ioAccess(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        ioWr <= wr; ioRd <= !wr; ioAddr <= a; ioWrData <= d;
        @(posedge core_clk);
        ioWr <= 1'b0; ioRd <= 1'b0;
        #1;
    endtask
    task automatic regWr(input logic [3:0] idx, input logic [7:0] d);
        ioAccess(1'b1, planar_write_read_pkg::INDEX_PORT, {4'h0, idx});
        ioAccess(1'b1, planar_write_read_pkg::DATA_PORT, d);
    endtask
    task automatic regRd(input logic [3:0] idx);
        ioAccess(1'b1, planar_write_read_pkg::INDEX_PORT, {4'h0, idx});
        ioAccess(1'b0, planar_write_read_pkg::DATA_PORT, 8'h00);
    endtask
    task automatic memRead(input logic [7:0] exp);
        @(posedge core_clk); memRd <= 1'b1;
        @(posedge core_clk); memRd <= 1'b0;
        #1;
        `CHK(memRdValid, 1'b1)
        `CHK(memRdData, exp)
    endtask
    task automatic memWrite(input logic [7:0] d, input logic [31:0] exp);
        @(posedge core_clk); memWr <= 1'b1; cpuWrData <= d;
        @(posedge core_clk); memWr <= 1'b0;
        #1;
        `CHK(mapWrEn, 1'b1)
        `CHK(mapWrData, exp)
        maps = exp;
    endtask
    function automatic logic [7:0] ror(logic [7:0] d, logic [2:0] r);
        return 8'({d, d} >> r);
    endfunction
    // Per map: source, function with latch, then mask merge
    function automatic logic [31:0] expWrite(logic [1:0] md, logic [3:0] fv, logic [3:0] en,
        logic [2:0] r, logic [1:0] f, logic [7:0] bm, logic [7:0] c, logic [31:0] lat);
        logic [7:0] s, m, l, o;
        logic [31:0] res;
        for (int n = 0; n < 4; n++) begin
            l = lat[8*n +: 8];
            m = bm;
            case (md)
                2'h0: s = en[n] ? {8{fv[n]}} : ror(c, r);
                2'h2: s = {8{c[n]}};
                2'h3: begin s = {8{fv[n]}}; m = ror(c, r) & bm; end
                default: s = l;
            endcase
            case (f)
                2'h1: o = s & l;
                2'h2: o = s | l;
                2'h3: o = s ^ l;
                default: o = s;
            endcase
            res[8*n +: 8] = (md == 2'h1) ? l : ((o & m) | (l & ~m));
        end
        return res;
    endfunction
    function automatic logic [7:0] expCompare(logic [31:0] mp, logic [3:0] cr, logic [3:0] ce);
        logic [7:0] b;
        b = 8'hff;
        for (int i = 0; i < 8; i++)
            for (int n = 0; n < 4; n++)
                if (ce[n] && (mp[8*n+i] != cr[n])) b[i] = 1'b0;
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Verdict and hang guard
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // Main sequence
    initial begin
        {ioWr, ioRd, memWr, memRd, presetEn} = 5'h00;
        ioAddr = 16'h0000; ioWrData = 8'h00; cpuWrData = 8'h00; presetData = 32'h00000000;
        maps = 32'h00000000; rst_n = 1'b0;
        regMask = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h0f, 8'h0f, 8'hff};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            regRd(i[3:0]); `CHK(ioRdData, 8'h00)
        end
        for (int i = 0; i < 9; i++) begin
            regWr(i[3:0], 8'hff); regRd(i[3:0]); `CHK(ioRdData, regMask[i])
        end
        `CHK(windowSetup, 4'hf)
        `CHK(oddEvenMode, 2'h3)
        // Extension registers, read back through the pointer left by the write
        for (int i = 9; i < 16; i++) begin
            regWr(i[3:0], 8'ha5 ^ 8'(i));
            ioAccess(1'b0, planar_write_read_pkg::DATA_PORT, 8'h00);
            `CHK(ioRdData, 8'ha5 ^ 8'(i))
        end
        for (int i = 0; i < 9; i++) regWr(i[3:0], 8'h00);
        ioAccess(1'b1, planar_write_read_pkg::INDEX_PORT, 8'hf3);
        ioAccess(1'b0, planar_write_read_pkg::INDEX_PORT, 8'h00); `CHK(ioRdData, 8'h03)
        ioAccess(1'b0, 16'h03cd, 8'h00); `CHK(ioRdData, 8'h00)
        // Plain reads of each map
        @(posedge core_clk); presetEn <= 1'b1; presetData <= 32'h0faaccf0;
        @(posedge core_clk); presetEn <= 1'b0; maps = 32'h0faaccf0;
        for (int p = 0; p < 4; p++) begin
            regWr(4'h4, 8'(p)); memRead(maps[8*p +: 8]);
        end
        // Compare reads over every reference
        regWr(4'h5, 8'h08);
        for (int c = 0; c < 16; c++) begin
            cen = c[0] ? 8'h0f : 8'h05;
            regWr(4'h2, 8'(c)); regWr(4'h7, cen);
            memRead(expCompare(maps, c[3:0], cen[3:0]));
        end
        // Writes over all modes, functions and rotate counts
        regWr(4'h4, 8'h00); regWr(4'h0, 8'h05); regWr(4'h1, 8'h06);
        for (int i = 0; i < 16; i++) begin
            mode = i[3:2]; fn = i[1:0]; rot = i[2:0];
            mask = i[0] ? 8'hff : 8'h5a; cpu = 8'h81 ^ 8'(i);
            regWr(4'h5, {6'h00, mode}); regWr(4'h3, {3'h0, fn, rot}); regWr(4'h8, mask);
            memRead(maps[7:0]);
            memWrite(cpu, expWrite(mode, 4'h5, 4'h6, rot, fn, mask, cpu, maps));
        end
        // Mode 0: map 0 filled, map 1 rotated by one, full mask
        regWr(4'h5, 8'h00); regWr(4'h1, 8'h01); regWr(4'h3, 8'h01); regWr(4'h8, 8'hff);
        cpu = 8'h3c;
        memRead(maps[7:0]);
        memWrite(cpu, expWrite(2'h0, 4'h5, 4'h1, 3'h1, 2'h0, 8'hff, cpu, maps));
        // Mode 0: XOR against latches, no rotation
        regWr(4'h3, 8'h18);
        cpu = 8'h96;
        memRead(maps[7:0]);
        memWrite(cpu, expWrite(2'h0, 4'h5, 4'h1, 3'h0, 2'h3, 8'hff, cpu, maps));
        // Zero mask keeps every latched bit
        regWr(4'h8, 8'h00);
        cpu = 8'h5a;
        memRead(maps[7:0]);
        memWrite(cpu, maps);
        // Compare read of all-zero maps against zero reference
        @(posedge core_clk); presetEn <= 1'b1; presetData <= 32'h00000000;
        @(posedge core_clk); presetEn <= 1'b0; maps = 32'h00000000;
        regWr(4'h5, 8'h08); regWr(4'h2, 8'h00); regWr(4'h7, 8'h0f);
        memRead(8'hff);
        finish_test();
    end
endmodule
